// ### hw/tpl_consts.svh
// Offsets, field positions, reset values and counts of the pulse timer
`ifndef TPL_CONSTS_SVH
`define TPL_CONSTS_SVH
// Register byte offsets
`define TPL_OFF_CTRL1 8'h00
`define TPL_OFF_CTRL2 8'h04
`define TPL_OFF_STATUS 8'h08
`define TPL_OFF_MASK 8'h0c
`define TPL_OFF_COUNT 8'h10
`define TPL_OFF_CAP1 8'h14
`define TPL_OFF_CAP2 8'h18
`define TPL_OFF_CMP1 8'h1c
`define TPL_OFF_CMP2 8'h20
// Status and mask bit positions
`define TPL_F_CAP1 7
`define TPL_F_MATCH1 6
`define TPL_F_OVF 5
`define TPL_F_CAP2 4
`define TPL_F_MATCH2 3
`define TPL_F_OFF 2
// Reset values and counter top
`define TPL_CTRL_RESET 8'h00
`define TPL_FLAGS_RESET 8'h00
`define TPL_CNT_RESET 16'hfffc
`define TPL_CNT_TOP 16'hffff
`define TPL_CMP_RESET 16'h8000
`define TPL_CAP_RESET 16'h0000
// Prescaler terminal counts for divide by 2, 4 and 8
`define TPL_PRE_TC2 3'd1
`define TPL_PRE_TC4 3'd3
`define TPL_PRE_TC8 3'd7
`endif

// ### hw/tpl_pkg.sv
// Types of the pulse timer
package tpl_pkg;
  typedef enum logic [1:0] {
    TPL_CLK_DIV4 = 2'b00,
    TPL_CLK_DIV2 = 2'b01,
    TPL_CLK_DIV8 = 2'b10,
    TPL_CLK_EXT = 2'b11
  } tpl_clk_e;
  typedef enum logic [1:0] {TPL_MODE_FREE, TPL_MODE_PULSE, TPL_MODE_PWM} tpl_mode_e;
  typedef struct packed {
    logic capture_irq_enable;
    logic match_irq_enable;
    logic overflow_irq_enable;
    logic force_two;
    logic force_one;
    logic level_during_pulse;
    logic trigger_edge_select;
    logic level_after_pulse;
  } tpl_ctrl1_s;
  typedef struct packed {
    logic compare_pin_one_enable;
    logic compare_pin_two_enable;
    logic single_pulse_select;
    logic pwm_select;
    tpl_clk_e timer_clock_select;
    logic capture_edge_two;
    logic ext_clock_edge;
  } tpl_ctrl2_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tpl_apb_req_s;
endpackage : tpl_pkg

// ### hw/tpl_timer.sv
// Sixteen-bit timer with single-pulse output, APB registers and interrupt
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tpl_consts.svh"
module tpl_timer #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_input_pin,
  input wire logic capture_input_two,
  input wire logic ext_clock_pin,
  input wire logic halt_mode,
  output logic compare_output_one,
  output logic compare_output_one_oe,
  output logic compare_output_two,
  output logic compare_output_two_oe,
  output logic timer_irq
);
  import tpl_pkg::*;

  // Elaboration check: map needs six address bits, eight are decoded
  if (ADDR_W < 6 || ADDR_W > 8)
  begin : g_bad_addr_w
    $error("tpl_timer: ADDR_W must lie between 6 and 8");
  end

  tpl_apb_req_s req;
  tpl_ctrl1_s ctrl1_r;
  tpl_ctrl2_s ctrl2_r;
  tpl_mode_e mode;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] mask_r;
  logic [7:0] seen_r;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic [15:0] cnt_r;
  logic [15:0] cap1_r;
  logic [15:0] cap2_r;
  logic [15:0] cmp1_r;
  logic [15:0] cmp2_r;
  logic [2:0] pre_r;
  logic [2:0] pre_tc;
  logic [31:0] rd_mux;
  logic hit;
  logic setup;
  logic done;
  logic wr;
  logic rd;
  logic trig_d_r;
  logic cap2_d_r;
  logic ext_d_r;
  logic halt_d_r;
  logic arm1_r;
  logic arm2_r;
  logic trig_edge;
  logic cap2_edge;
  logic ext_edge;
  logic halt_exit;
  logic run;
  logic tick;
  logic match1;
  logic match2;
  logic pulse_start;
  logic pwm_reload;
  logic cap1_evt;
  logic cap2_evt;
  logic ovf_evt;

  assign req = '{psel, penable, pwrite, 8'(paddr), pwdata}; // Narrow bus zero-extended
  assign setup = req.psel && !req.penable;
  assign done = req.psel && req.penable && pready;
  assign wr = done && req.pwrite;
  assign rd = done && !req.pwrite;

  // Operating mode, modulation first
  always_comb
  begin
    if (ctrl2_r.pwm_select)
      mode = TPL_MODE_PWM;
    else if (ctrl2_r.single_pulse_select)
      mode = TPL_MODE_PULSE;
    else
      mode = TPL_MODE_FREE;
  end

  // Edge detection on the pins
  assign trig_edge = ctrl1_r.trigger_edge_select ? (trigger_input_pin && !trig_d_r)
                                                 : (!trigger_input_pin && trig_d_r);
  assign cap2_edge = ctrl2_r.capture_edge_two ? (capture_input_two && !cap2_d_r)
                                              : (!capture_input_two && cap2_d_r);
  assign ext_edge = ctrl2_r.ext_clock_edge ? (ext_clock_pin && !ext_d_r)
                                           : (!ext_clock_pin && ext_d_r);
  assign halt_exit = halt_d_r && !halt_mode;
  assign run = !halt_mode && !flags_r[`TPL_F_OFF];

  // Previous pin levels
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      trig_d_r <= 1'b0;
      cap2_d_r <= 1'b0;
      ext_d_r <= 1'b0;
      halt_d_r <= 1'b0;
    end
    else
    begin
      trig_d_r <= trigger_input_pin;
      cap2_d_r <= capture_input_two;
      ext_d_r <= ext_clock_pin;
      halt_d_r <= halt_mode;
    end
  end

  // Prescaler terminal count
  always_comb
  begin
    unique case (ctrl2_r.timer_clock_select)
      TPL_CLK_DIV2: pre_tc = `TPL_PRE_TC2;
      TPL_CLK_DIV8: pre_tc = `TPL_PRE_TC8;
      default: pre_tc = `TPL_PRE_TC4;
    endcase
  end
  assign tick = (ctrl2_r.timer_clock_select == TPL_CLK_EXT) ? (run && ext_edge)
                                                            : (run && pre_r == pre_tc);

  // Prescaler, frozen with the counter
  always_ff @(posedge clk)
  begin
    if (!rstn)
      pre_r <= 3'd0;
    else if (run)
      pre_r <= (pre_r == pre_tc) ? 3'd0 : pre_r + 3'd1;
  end

  // Timer events
  assign match1 = tick && cnt_r == cmp1_r;
  assign match2 = tick && cnt_r == cmp2_r;
  assign pulse_start = (mode == TPL_MODE_PULSE) && trig_edge && run;
  assign pwm_reload = (mode == TPL_MODE_PWM) && match2;
  assign cap1_evt = ((mode == TPL_MODE_FREE) && trig_edge && !halt_mode)
                    || (halt_exit && arm1_r);
  assign cap2_evt = (cap2_edge && !halt_mode) || (halt_exit && arm2_r);
  assign ovf_evt = tick && cnt_r == `TPL_CNT_TOP && !pulse_start && !pwm_reload;

  // Capture edges seen in halt arm the capture
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      arm1_r <= 1'b0;
      arm2_r <= 1'b0;
    end
    else if (halt_mode)
    begin
      if (trig_edge && mode == TPL_MODE_FREE)
        arm1_r <= 1'b1;
      if (cap2_edge)
        arm2_r <= 1'b1;
    end
    else
    begin
      arm1_r <= 1'b0;
      arm2_r <= 1'b0;
    end
  end

  // Free-running counter with reloads
  always_ff @(posedge clk)
  begin
    if (!rstn)
      cnt_r <= `TPL_CNT_RESET;
    else if (pulse_start || (pwm_reload && run))
      cnt_r <= `TPL_CNT_RESET;
    else if (tick)
      cnt_r <= cnt_r + 16'h0001;
  end

  // Capture registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cap1_r <= `TPL_CAP_RESET;
      cap2_r <= `TPL_CAP_RESET;
    end
    else
    begin
      if (cap1_evt || pulse_start)
        cap1_r <= cnt_r;
      if (cap2_evt)
        cap2_r <= cnt_r;
    end
  end

  // Flag set and clear, set wins
  always_comb
  begin
    set_v = 8'h00;
    set_v[`TPL_F_CAP1] = cap1_evt || pulse_start || pwm_reload;
    set_v[`TPL_F_MATCH1] = match1 && mode == TPL_MODE_FREE;
    set_v[`TPL_F_OVF] = ovf_evt;
    set_v[`TPL_F_CAP2] = cap2_evt;
    set_v[`TPL_F_MATCH2] = match2 && mode != TPL_MODE_PWM;
    clr_v = 8'h00;
    if (wr && req.paddr == `TPL_OFF_STATUS)
      clr_v = req.pwdata[7:0] & 8'hf8;
    if (done)
    begin
      // Two-step clear: data access after status read
      if (req.paddr == `TPL_OFF_CAP1)
        clr_v[`TPL_F_CAP1] = clr_v[`TPL_F_CAP1] | seen_r[`TPL_F_CAP1];
      if (req.paddr == `TPL_OFF_CMP1)
        clr_v[`TPL_F_MATCH1] = clr_v[`TPL_F_MATCH1] | seen_r[`TPL_F_MATCH1];
      if (req.paddr == `TPL_OFF_COUNT)
        clr_v[`TPL_F_OVF] = clr_v[`TPL_F_OVF] | seen_r[`TPL_F_OVF];
      if (req.paddr == `TPL_OFF_CAP2)
        clr_v[`TPL_F_CAP2] = clr_v[`TPL_F_CAP2] | seen_r[`TPL_F_CAP2];
      if (req.paddr == `TPL_OFF_CMP2)
        clr_v[`TPL_F_MATCH2] = clr_v[`TPL_F_MATCH2] | seen_r[`TPL_F_MATCH2];
    end
    flags_nxt = (flags_r & ~clr_v) | set_v;
    if (wr && req.paddr == `TPL_OFF_STATUS)
      flags_nxt[`TPL_F_OFF] = req.pwdata[`TPL_F_OFF];
    flags_nxt[1:0] = 2'b00;
  end

  // Status flags
  always_ff @(posedge clk)
  begin
    if (!rstn)
      flags_r <= `TPL_FLAGS_RESET;
    else
      flags_r <= flags_nxt;
  end

  // Flags seen by a status read arm their clear
  always_ff @(posedge clk)
  begin
    if (!rstn)
      seen_r <= 8'h00;
    else if (rd && req.paddr == `TPL_OFF_STATUS)
      seen_r <= prdata[7:0] & 8'hf8;
    else
      seen_r <= seen_r & ~clr_v;
  end

  // Software-written registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl1_r <= tpl_ctrl1_s'(`TPL_CTRL_RESET);
      ctrl2_r <= tpl_ctrl2_s'(`TPL_CTRL_RESET);
      mask_r <= `TPL_FLAGS_RESET;
      cmp1_r <= `TPL_CMP_RESET;
      cmp2_r <= `TPL_CMP_RESET;
    end
    else if (wr)
    begin
      unique case (req.paddr)
        `TPL_OFF_CTRL1: ctrl1_r <= tpl_ctrl1_s'(req.pwdata[7:0]);
        `TPL_OFF_CTRL2: ctrl2_r <= tpl_ctrl2_s'(req.pwdata[7:0]);
        `TPL_OFF_MASK: mask_r <= req.pwdata[7:0] & 8'hf8;
        `TPL_OFF_CMP1: cmp1_r <= req.pwdata[15:0];
        `TPL_OFF_CMP2: cmp2_r <= req.pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Compare output one: pulse, modulation or plain compare
  always_ff @(posedge clk)
  begin
    if (!rstn)
      compare_output_one <= 1'b0;
    else if (run)
    begin
      unique case (mode)
        TPL_MODE_PULSE:
          if (pulse_start)
            compare_output_one <= ctrl1_r.level_during_pulse;
          else if (match1)
            compare_output_one <= ctrl1_r.level_after_pulse;
        TPL_MODE_PWM:
          if (match2)
            compare_output_one <= ctrl1_r.level_during_pulse;
          else if (match1)
            compare_output_one <= ctrl1_r.level_after_pulse;
        TPL_MODE_FREE:
          if (match1 || ctrl1_r.force_one)
            compare_output_one <= ctrl1_r.level_after_pulse;
      endcase
    end
  end

  // Compare output two: no waveform outside plain compare
  always_ff @(posedge clk)
  begin
    if (!rstn)
      compare_output_two <= 1'b0;
    else if (run && mode == TPL_MODE_FREE && (match2 || ctrl1_r.force_two))
      compare_output_two <= ctrl1_r.level_during_pulse;
  end

  // Pin enables, dropped while the timer is switched off
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      compare_output_one_oe <= 1'b0;
      compare_output_two_oe <= 1'b0;
    end
    else
    begin
      compare_output_one_oe <= ctrl2_r.compare_pin_one_enable && !flags_r[`TPL_F_OFF];
      compare_output_two_oe <= ctrl2_r.compare_pin_two_enable && !flags_r[`TPL_F_OFF];
    end
  end

  // Interrupt: flags gated by group enable and mask
  always_ff @(posedge clk)
  begin
    if (!rstn)
      timer_irq <= 1'b0;
    else
      timer_irq <= |(flags_r & mask_r & {ctrl1_r.capture_irq_enable,
                                         ctrl1_r.match_irq_enable,
                                         ctrl1_r.overflow_irq_enable,
                                         ctrl1_r.capture_irq_enable,
                                         ctrl1_r.match_irq_enable, 3'b000});
  end

  // Read mux and decode
  always_comb
  begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (req.paddr)
      `TPL_OFF_CTRL1: rd_mux[7:0] = ctrl1_r;
      `TPL_OFF_CTRL2: rd_mux[7:0] = ctrl2_r;
      `TPL_OFF_STATUS: rd_mux[7:0] = flags_r;
      `TPL_OFF_MASK: rd_mux[7:0] = mask_r;
      `TPL_OFF_COUNT: rd_mux[15:0] = cnt_r;
      `TPL_OFF_CAP1: rd_mux[15:0] = cap1_r;
      `TPL_OFF_CAP2: rd_mux[15:0] = cap2_r;
      `TPL_OFF_CMP1: rd_mux[15:0] = cmp1_r;
      `TPL_OFF_CMP2: rd_mux[15:0] = cmp2_r;
      default: hit = 1'b0;
    endcase
  end

  // APB answer one cycle after setup
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !hit;
      if (setup)
        prdata <= req.pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_pulse_reload: assert property (pulse_start |=>
    cnt_r == `TPL_CNT_RESET && cap1_r == $past(cnt_r) && flags_r[`TPL_F_CAP1])
    else $error("pulse start did not reload and capture");
  a_pulse_level: assert property (pulse_start |=>
    compare_output_one == $past(ctrl1_r.level_during_pulse))
    else $error("pulse start level wrong");
  a_pulse_end: assert property ((mode == TPL_MODE_PULSE && run && match1 && !pulse_start)
    |=> compare_output_one == $past(ctrl1_r.level_after_pulse))
    else $error("pulse end level wrong");
  a_edge_polarity: assert property (pulse_start |->
    trigger_input_pin == ctrl1_r.trigger_edge_select && trig_d_r != trigger_input_pin)
    else $error("pulse started on wrong edge");
  a_prescale_div8: assert property ((tick && run &&
    ctrl2_r.timer_clock_select == TPL_CLK_DIV8) |=> !tick [*7])
    else $error("divide by eight ticked early");
  a_capture_irq: assert property ((flags_r[`TPL_F_CAP1] && mask_r[`TPL_F_CAP1] &&
    ctrl1_r.capture_irq_enable) |=> timer_irq)
    else $error("capture flag raised no interrupt");
  a_clear_order: assert property ($fell(flags_r[`TPL_F_CAP1]) |->
    $past(seen_r[`TPL_F_CAP1]) || $past(wr && req.paddr == `TPL_OFF_STATUS))
    else $error("capture flag cleared without status read");
  a_no_match_one: assert property ($rose(flags_r[`TPL_F_MATCH1]) |->
    $past(mode) == TPL_MODE_FREE)
    else $error("match one set outside plain compare");
  a_pwm_wins: assert property ((ctrl2_r.pwm_select && trig_edge && !match2 && !halt_exit)
    |=> cap1_r == $past(cap1_r))
    else $error("trigger acted in modulation");
  a_halt_freeze: assert property ((halt_mode && halt_d_r) |-> cnt_r == $past(cnt_r))
    else $error("counter moved in halt");
  a_halt_capture: assert property ((halt_exit && arm2_r) |=>
    flags_r[`TPL_F_CAP2] && cap2_r == $past(cnt_r))
    else $error("armed capture lost at halt exit");
  a_no_pwm_match: assert property ($rose(flags_r[`TPL_F_MATCH2]) |->
    !$past(ctrl2_r.pwm_select))
    else $error("match two set in modulation");

  c_pulse_start: cover property (pulse_start);
  c_pulse_end: cover property (pulse_start ##[1:300] (mode == TPL_MODE_PULSE && match1));
  c_halt_capture: cover property (halt_exit && arm2_r);
  c_irq: cover property ($rose(timer_irq));
endmodule : tpl_timer
`default_nettype wire

// ### test/tpl_pin_partner.sv
// Pin-side partner: trigger source, capture two source, external clock, pulse load
`timescale 1ns/1ps
`default_nettype none
module tpl_pin_partner (
  input wire logic clk,
  input wire logic ext_en,
  input wire logic out_one,
  input wire logic out_one_oe,
  output logic trig,
  output logic cap_two,
  output logic ext_clk
);
  int ext_cnt;
  logic pin_level;

  // Pull-up load on the pulse pin while it is not driven
  assign pin_level = out_one_oe ? out_one : 1'b1;

  initial
  begin
    trig = 1'b0;
    cap_two = 1'b0;
    ext_clk = 1'b0;
    ext_cnt = 0;
  end

  // External count clock, ten cycles a period, still while disabled
  always @(posedge clk)
  begin
    if (!ext_en)
      ext_cnt <= 0;
    else if (ext_cnt == 4)
    begin
      ext_cnt <= 0;
      ext_clk <= ~ext_clk;
    end
    else
      ext_cnt <= ext_cnt + 1;
  end

  // Inactive level first, then the active edge
  task automatic edge_trig(input logic rising);
    trig <= ~rising;
    repeat (3) @(posedge clk);
    trig <= rising;
    @(posedge clk);
  endtask : edge_trig

  // Rising edge on the second capture input
  task automatic edge_cap2();
    cap_two <= 1'b0;
    repeat (3) @(posedge clk);
    cap_two <= 1'b1;
    @(posedge clk);
  endtask : edge_cap2

  // Cycles the pin stays high, zero if no pulse starts
  task automatic measure(output int cycles);
    int w;
    w = 0;
    cycles = 0;
    while (pin_level !== 1'b1 && w < 40)
    begin
      @(posedge clk);
      w++;
    end
    while (pin_level === 1'b1 && cycles < 400)
    begin
      @(posedge clk);
      cycles++;
    end
  endtask : measure
endmodule : tpl_pin_partner
`default_nettype wire

// ### test/timer_one_pulse_lowpower_irq_tb_top.sv
// Testbench of the pulse timer: APB driver, result queue, pulse scenarios
`timescale 1ns/1ps
`default_nettype none
`include "tpl_consts.svh"
module timer_one_pulse_lowpower_irq_tb_top;
  import tpl_pkg::*;
  typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} tpl_note_s;
  logic clk, rstn, halt, ext_en, trig, cap_two, ext_clk;
  logic pready, pslverr, out1, out1_oe, out2, out2_oe, irq;
  logic [31:0] prdata, rdv, c1, c2;
  logic [15:0] cmp;
  tpl_apb_req_s req;
  tpl_note_s notes[$];
  tpl_note_s nt;
  int error_cnt, checks_done, len, n;
  logic [1:0] codes [4] = '{2'b01, 2'b00, 2'b10, 2'b11};
  int divs [4] = '{2, 4, 8, 10};

  tpl_timer u_dut (.clk(clk), .rstn(rstn), .psel(req.psel), .penable(req.penable),
    .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_input_pin(trig),
    .capture_input_two(cap_two), .ext_clock_pin(ext_clk), .halt_mode(halt),
    .compare_output_one(out1), .compare_output_one_oe(out1_oe),
    .compare_output_two(out2), .compare_output_two_oe(out2_oe), .timer_irq(irq));

  tpl_pin_partner u_partner (.clk(clk), .ext_en(ext_en), .out_one(out1),
    .out_one_oe(out1_oe), .trig(trig), .cap_two(cap_two), .ext_clk(ext_clk));

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // One APB transfer, expectation noted first, one idle edge after release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      input logic [31:0] exp, input logic [31:0] msk, input logic err);
    notes.push_back('{data: exp, mask: msk, err: err});
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    // Wait for the answer; only the hang guard ends a stuck transfer
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdv = prdata;
    req <= '0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask : rd

  // Oldest note against each completed transfer
  always @(posedge clk)
  begin
    if (rstn && req.psel && req.penable && pready === 1'b1)
    begin
      if (notes.size() == 0)
        check(32'hdead, 32'h0);
      else
      begin
        nt = notes.pop_front();
        check(prdata & nt.mask, nt.data & nt.mask);
        check({31'h0, pslverr}, {31'h0, nt.err});
      end
    end
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    rstn = 1'b0;
    req = '0;
    halt = 1'b0;
    ext_en = 1'b0;
    error_cnt = 0;
    checks_done = 0;
    void'($urandom(32'h8e9c));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`TPL_OFF_STATUS, 32'h0, 32'hffffffdf);
    rd(`TPL_OFF_CTRL1, 32'h0, 32'hffffffff);
    rd(`TPL_OFF_CTRL2, 32'h0, 32'hffffffff);
    rd(`TPL_OFF_MASK, 32'h0, 32'hffffffff);
    rd(`TPL_OFF_CMP1, 32'h8000, 32'hffffffff);
    rd(`TPL_OFF_CMP2, 32'h8000, 32'hffffffff);
    apb(1'b1, 8'h24, 32'hff, 32'h0, 32'hffffffff, 1'b1);
    // Pulses over every clock source, alternating trigger polarity
    for (int i = 0; i < 4; i++)
    begin
      cmp = 16'(1 + $urandom % 8);
      wr(`TPL_OFF_MASK, 32'h88);
      wr(`TPL_OFF_CMP1, {16'h0, cmp});
      wr(`TPL_OFF_CMP2, 32'h0);
      wr(`TPL_OFF_CTRL1, 32'h84 | ((i % 2 == 0) ? 32'h2 : 32'h0));
      wr(`TPL_OFF_CTRL2, 32'he3 | {28'h0, codes[i], 2'b00});
      // Clear after single-pulse is on: plain compare may have matched meanwhile
      wr(`TPL_OFF_STATUS, 32'hf8);
      ext_en <= (codes[i] == 2'b11);
      fork
        u_partner.edge_trig(i % 2 == 0);
        u_partner.measure(len);
      join
      n = 4 + cmp;
      check({31'h0, len >= (n - 1) * divs[i] && len <= (n + 1) * divs[i] + 3}, 32'h1);
      check({30'h0, out2, out2_oe}, 32'h1);
      rd(`TPL_OFF_STATUS, 32'ha8, 32'he8);
      check({31'h0, irq}, 32'h1);
      rd(`TPL_OFF_CAP1, 32'h0, 32'hffff0000);
      rd(`TPL_OFF_STATUS, 32'h0, 32'h80);
      check({31'h0, irq}, 32'h0);
      ext_en <= 1'b0;
    end
    // Halt: frozen counter, capture armed and completed at wake
    wr(`TPL_OFF_CTRL2, 32'he7);
    wr(`TPL_OFF_STATUS, 32'hf8);
    halt <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`TPL_OFF_COUNT, 32'h0, 32'hffff0000);
    c1 = rdv;
    u_partner.edge_cap2();
    repeat (10) @(posedge clk);
    rd(`TPL_OFF_COUNT, 32'h0, 32'hffff0000);
    c2 = rdv;
    check(c2, c1);
    rd(`TPL_OFF_STATUS, 32'h0, 32'h10);
    halt <= 1'b0;
    repeat (3) @(posedge clk);
    rd(`TPL_OFF_STATUS, 32'h10, 32'h10);
    rd(`TPL_OFF_COUNT, 32'h0, 32'hffff0000);
    check({31'h0, rdv[15:0] - c1[15:0] > 16'h0 && rdv[15:0] - c1[15:0] < 16'h14}, 32'h1);
    // Modulation over single-pulse: a trigger first reloads the counter near top
    wr(`TPL_OFF_CMP1, 32'h2);
    wr(`TPL_OFF_CMP2, 32'h6);
    u_partner.edge_trig(1'b0);
    wr(`TPL_OFF_CTRL2, 32'hf4);
    wr(`TPL_OFF_STATUS, 32'hf8);
    rd(`TPL_OFF_CAP1, 32'h0, 32'hffff0000);
    c1 = rdv;
    u_partner.edge_trig(1'b0);
    // First measurement may start mid-pulse, the second sees a whole one
    u_partner.measure(len);
    u_partner.measure(len);
    check({31'h0, len >= 10 && len <= 17}, 32'h1);
    rd(`TPL_OFF_STATUS, 32'ha0, 32'he8);
    rd(`TPL_OFF_CAP1, 32'h0, 32'hffff0000);
    check(rdv, c1);
    // Timer off: pins released, counter frozen
    wr(`TPL_OFF_STATUS, 32'h04);
    repeat (2) @(posedge clk);
    check({30'h0, out1_oe, out2_oe}, 32'h0);
    rd(`TPL_OFF_COUNT, 32'h0, 32'hffff0000);
    c1 = rdv;
    repeat (6) @(posedge clk);
    rd(`TPL_OFF_COUNT, 32'h0, 32'hffff0000);
    check(rdv, c1);
    // Plain compare: forced levels reach both pins
    wr(`TPL_OFF_CTRL2, 32'hc4);
    wr(`TPL_OFF_STATUS, 32'h00);
    wr(`TPL_OFF_CTRL1, 32'h1f);
    repeat (2) @(posedge clk);
    check({30'h0, out1, out2}, 32'h3);
    check({30'h0, out1_oe, out2_oe}, 32'h3);
    repeat (5) @(posedge clk);
    end_sim();
  end
endmodule : timer_one_pulse_lowpower_irq_tb_top
`default_nettype wire
